// >>> hdl/edpc_top.sv
// Energy detect power control for one port, with AHB-Lite registers.
// Assumes line events are single-cycle pulses synchronous to hclk.
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module edpc_top #(
	parameter longint QUIET_CYC = edpc_pkg::EDPC_QUIET_CYC,
	parameter int SEQ_CYC = edpc_pkg::EDPC_SEQ_CYC
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Strap sampled after reset
	input wire logic strap_allow,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Line front end
	input wire logic energy_present,
	input wire logic data_event,
	input wire logic error_event,
	output logic rx_power_on,
	output logic detect_pulse,
	// Interrupt
	output logic irq
);

	if (QUIET_CYC < 2 || QUIET_CYC > 64'hFFFFFFFF || SEQ_CYC < 1
		|| SEQ_CYC > 255) begin : g_bad_param
		$error("edpc_top: parameter out of range");
	end

	// ********************************
	// Bus slave
	// ********************************
	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] wr_addr_r, wr_addr_nxt;
	logic strap_done_r, strap_done_nxt;
	edpc_pkg::edpc_cfg_t cfg_r, cfg_nxt;
	logic man_r, man_nxt;
	logic err_met_r, err_met_nxt;
	logic data_met_r, data_met_nxt;
	logic [edpc_pkg::EDPC_IRQ_W-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
	logic [31:0] hrdata_nxt;
	logic [edpc_pkg::EDPC_IRQ_W-1:0] irq_ev;
	logic ctrl_rd;
	edpc_pkg::edpc_state_t st_r, st_nxt;
	logic [7:0] seq_cnt_r, seq_cnt_nxt;
	logic [2:0] pulse_cnt_r, pulse_cnt_nxt;
	logic pulse_r, pulse_nxt;
	logic [3:0] data_cnt_r, data_cnt_nxt, err_cnt_r, err_cnt_nxt;
	logic [31:0] quiet_r, quiet_nxt;
	logic data_hit, err_hit;

	wire logic addr_ph = hsel && hready && htrans[1];
	wire logic [15:0] ctrl_word = {cfg_r.allow, cfg_r.auto_up, cfg_r.auto_dn, man_r,
		cfg_r.burst_off, rx_power_on, err_met_r, data_met_r, cfg_r.err_thr, cfg_r.data_thr};

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign ctrl_rd = addr_ph && !hwrite && haddr[7:0] == edpc_pkg::EDPC_CTRL_OFS;

	always_comb begin
		wr_pend_nxt = addr_ph && hwrite;
		wr_addr_nxt = addr_ph ? haddr[7:0] : wr_addr_r;
		hrdata_nxt = hrdata;
		if (addr_ph && !hwrite) begin
			case (haddr[7:0])
				edpc_pkg::EDPC_CTRL_OFS: hrdata_nxt = {16'h0000, ctrl_word};
				edpc_pkg::EDPC_IRQ_STAT_OFS: hrdata_nxt = {28'h0000000, irq_stat_r};
				edpc_pkg::EDPC_IRQ_MASK_OFS: hrdata_nxt = {28'h0000000, irq_mask_r};
				default: hrdata_nxt = 32'h00000000;
			endcase
		end
		// Strap lands one cycle after release, never inside the reset branch
		strap_done_nxt = 1'b1;
		cfg_nxt = cfg_r;
		if (!strap_done_r) begin
			cfg_nxt.allow = strap_allow;
		end
		man_nxt = 1'b0;
		irq_mask_nxt = irq_mask_r;
		if (wr_pend_r && wr_addr_r == edpc_pkg::EDPC_CTRL_OFS) begin
			cfg_nxt.allow = hwdata[edpc_pkg::EDPC_ALLOW_BIT];
			cfg_nxt.auto_up = hwdata[edpc_pkg::EDPC_AUTO_UP_BIT];
			cfg_nxt.auto_dn = hwdata[edpc_pkg::EDPC_AUTO_DN_BIT];
			cfg_nxt.burst_off = hwdata[edpc_pkg::EDPC_BURST_OFF_BIT];
			cfg_nxt.err_thr = hwdata[edpc_pkg::EDPC_ERR_THR_LSB+:4];
			cfg_nxt.data_thr = hwdata[edpc_pkg::EDPC_DATA_THR_LSB+:4];
			man_nxt = hwdata[edpc_pkg::EDPC_MAN_BIT];
		end
		if (wr_pend_r && wr_addr_r == edpc_pkg::EDPC_IRQ_MASK_OFS) begin
			irq_mask_nxt = hwdata[edpc_pkg::EDPC_IRQ_W-1:0];
		end
		// Set wins over both clear-on-read and write-one-to-clear
		err_met_nxt = (err_met_r && !ctrl_rd) || err_hit;
		data_met_nxt = (data_met_r && !ctrl_rd) || data_hit;
		irq_stat_nxt = irq_stat_r;
		if (wr_pend_r && wr_addr_r == edpc_pkg::EDPC_IRQ_STAT_OFS) begin
			irq_stat_nxt = irq_stat_r & ~hwdata[edpc_pkg::EDPC_IRQ_W-1:0];
		end
		irq_stat_nxt = irq_stat_nxt | irq_ev;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata <= 32'h00000000;
			strap_done_r <= 1'b0;
			cfg_r <= '{allow: 1'b0, auto_up: edpc_pkg::EDPC_AUTO_RST,
				auto_dn: edpc_pkg::EDPC_AUTO_RST, burst_off: 1'b0,
				err_thr: edpc_pkg::EDPC_THR_RST, data_thr: edpc_pkg::EDPC_THR_RST};
			man_r <= 1'b0;
			err_met_r <= 1'b0;
			data_met_r <= 1'b0;
			irq_stat_r <= '0;
			irq_mask_r <= '0;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			hrdata <= hrdata_nxt;
			strap_done_r <= strap_done_nxt;
			cfg_r <= cfg_nxt;
			man_r <= man_nxt;
			err_met_r <= err_met_nxt;
			data_met_r <= data_met_nxt;
			irq_stat_r <= irq_stat_nxt;
			irq_mask_r <= irq_mask_nxt;
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// ********************************
	// Event counting and power sequencing
	// ********************************
	// Counters saturate at 15, so a threshold of 0 is met by the first event
	assign data_hit = cfg_r.allow && data_event && st_r == edpc_pkg::EDPC_DOWN
		&& data_cnt_r + 5'd1 >= {1'b0, cfg_r.data_thr};
	assign err_hit = cfg_r.allow && error_event
		&& err_cnt_r + 5'd1 >= {1'b0, cfg_r.err_thr};

	always_comb begin
		st_nxt = st_r;
		seq_cnt_nxt = seq_cnt_r;
		pulse_cnt_nxt = pulse_cnt_r;
		pulse_nxt = 1'b0;
		data_cnt_nxt = data_cnt_r;
		err_cnt_nxt = err_cnt_r;
		quiet_nxt = quiet_r;
		irq_ev = '0;
		if (cfg_r.allow) begin
			if (data_event) begin
				quiet_nxt = 32'h00000000;
				if (data_cnt_r != 4'hF) data_cnt_nxt = data_cnt_r + 4'h1;
			end else if (quiet_r >= 32'(QUIET_CYC - 1)) begin
				quiet_nxt = 32'h00000000;
				data_cnt_nxt = 4'h0;
				err_cnt_nxt = 4'h0;
			end else begin
				quiet_nxt = quiet_r + 32'h00000001;
			end
			if (error_event && err_cnt_r != 4'hF) err_cnt_nxt = err_cnt_r + 4'h1;
		end
		irq_ev[edpc_pkg::EDPC_IRQ_DATA_BIT] = data_hit;
		irq_ev[edpc_pkg::EDPC_IRQ_ERR_BIT] = err_hit;
		case (st_r)
			edpc_pkg::EDPC_DOWN: begin
				if (cfg_r.allow && (man_r || (cfg_r.auto_up && data_hit))) begin
					st_nxt = edpc_pkg::EDPC_GO_UP;
					pulse_cnt_nxt = cfg_r.burst_off ? 3'h1 : edpc_pkg::EDPC_BURST_LEN;
					seq_cnt_nxt = 8'h00;
				end
			end
			edpc_pkg::EDPC_GO_UP: begin
				// One pulse every other cycle
				if (pulse_cnt_r != 3'h0 && !pulse_r) begin
					pulse_nxt = 1'b1;
					pulse_cnt_nxt = pulse_cnt_r - 3'h1;
				end
				seq_cnt_nxt = seq_cnt_r + 8'h01;
				if (pulse_cnt_r == 3'h0 && seq_cnt_r >= 8'(SEQ_CYC - 1)) begin
					st_nxt = edpc_pkg::EDPC_UP;
					irq_ev[edpc_pkg::EDPC_IRQ_UP_BIT] = 1'b1;
					data_cnt_nxt = 4'h0;
					err_cnt_nxt = 4'h0;
				end
			end
			edpc_pkg::EDPC_UP: begin
				if (cfg_r.allow && (man_r || (cfg_r.auto_dn && !energy_present))) begin
					st_nxt = edpc_pkg::EDPC_GO_DOWN;
					seq_cnt_nxt = 8'h00;
				end
			end
			edpc_pkg::EDPC_GO_DOWN: begin
				seq_cnt_nxt = seq_cnt_r + 8'h01;
				if (seq_cnt_r >= 8'(SEQ_CYC - 1)) begin
					st_nxt = edpc_pkg::EDPC_DOWN;
					irq_ev[edpc_pkg::EDPC_IRQ_DOWN_BIT] = 1'b1;
					data_cnt_nxt = 4'h0;
					err_cnt_nxt = 4'h0;
				end
			end
			default: st_nxt = edpc_pkg::EDPC_DOWN;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= edpc_pkg::EDPC_DOWN;
			seq_cnt_r <= 8'h00;
			pulse_cnt_r <= 3'h0;
			pulse_r <= 1'b0;
			data_cnt_r <= 4'h0;
			err_cnt_r <= 4'h0;
			quiet_r <= 32'h00000000;
		end else begin
			st_r <= st_nxt;
			seq_cnt_r <= seq_cnt_nxt;
			pulse_cnt_r <= pulse_cnt_nxt;
			pulse_r <= pulse_nxt;
			data_cnt_r <= data_cnt_nxt;
			err_cnt_r <= err_cnt_nxt;
			quiet_r <= quiet_nxt;
		end
	end

	// Power state moves only at the end of a sequence
	assign rx_power_on = st_r == edpc_pkg::EDPC_UP || st_r == edpc_pkg::EDPC_GO_DOWN;
	assign detect_pulse = pulse_r;

	// ********************************
	// Assertions
	// ********************************
	man_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		man_r |=> !man_r) else $error("manual bit did not self-clear");
	up_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r == edpc_pkg::EDPC_DOWN && cfg_r.allow && cfg_r.auto_up && data_hit
		|=> st_r == edpc_pkg::EDPC_GO_UP) else $error("no power-up on threshold");
	down_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r == edpc_pkg::EDPC_UP && cfg_r.allow && cfg_r.auto_dn && !energy_present
		|=> st_r == edpc_pkg::EDPC_GO_DOWN) else $error("no power-down on silence");
	allow_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!cfg_r.allow && st_r == edpc_pkg::EDPC_DOWN |=> st_r == edpc_pkg::EDPC_DOWN)
		else $error("left power-down while disabled");
	strap_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!strap_done_r && !wr_pend_r |=> cfg_r.allow == $past(strap_allow))
		else $error("enable bit not loaded from strap");
	burst_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(st_r == edpc_pkg::EDPC_GO_UP) && cfg_r.burst_off |-> pulse_cnt_r == 3'h1)
		else $error("burst not single");
	burst_four_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(st_r == edpc_pkg::EDPC_GO_UP) && !cfg_r.burst_off |-> pulse_cnt_r == 3'h4)
		else $error("burst not four");
	pulse_state_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r != edpc_pkg::EDPC_GO_UP |-> !pulse_r)
		else $error("detect pulse outside power-up");
	pwr_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r == edpc_pkg::EDPC_GO_UP ##1 st_r == edpc_pkg::EDPC_UP |-> ctrl_word[10])
		else $error("power bit low after power-up");
	data_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		data_hit |=> data_met_r) else $error("data flag not set");
	err_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		err_met_r && ctrl_rd && !err_hit |=> !err_met_r) else $error("error flag not cleared");
	count_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r != st_nxt && (st_nxt == edpc_pkg::EDPC_UP || st_nxt == edpc_pkg::EDPC_DOWN)
		|=> data_cnt_r == 4'h0) else $error("count not restarted");
	quiet_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
		cfg_r.allow && !data_event && quiet_r >= 32'(QUIET_CYC - 1) |=> data_cnt_r == 4'h0)
		else $error("count kept after quiet time");
	thr_reset_a: assert property (@(posedge hclk)
		$rose(hresetn) |-> cfg_r.data_thr == edpc_pkg::EDPC_THR_RST
		&& cfg_r.err_thr == edpc_pkg::EDPC_THR_RST) else $error("threshold reset value wrong");

	up_cov: cover property (@(posedge hclk) disable iff (!hresetn)
		st_r == edpc_pkg::EDPC_GO_UP ##1 st_r == edpc_pkg::EDPC_UP);
	down_cov: cover property (@(posedge hclk) disable iff (!hresetn)
		st_r == edpc_pkg::EDPC_GO_DOWN ##1 st_r == edpc_pkg::EDPC_DOWN);
	man_cov: cover property (@(posedge hclk) disable iff (!hresetn)
		man_r && st_r == edpc_pkg::EDPC_UP);
	irq_cov: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));

endmodule // edpc_top

// >>> hdl/edpc_pkg.sv
// Package for the energy detect power control block.
// Assumes a 50 MHz bus clock and an AHB-Lite register port.
package edpc_pkg;

	// ********************************
	// Register map (byte addresses)
	// ********************************
	localparam logic [7:0] EDPC_CTRL_OFS = 8'h00;
	localparam logic [7:0] EDPC_IRQ_STAT_OFS = 8'h04;
	localparam logic [7:0] EDPC_IRQ_MASK_OFS = 8'h08;

	// ********************************
	// Field positions
	// ********************************
	localparam int EDPC_ALLOW_BIT = 15;
	localparam int EDPC_AUTO_UP_BIT = 14;
	localparam int EDPC_AUTO_DN_BIT = 13;
	localparam int EDPC_MAN_BIT = 12;
	localparam int EDPC_BURST_OFF_BIT = 11;
	localparam int EDPC_PWR_BIT = 10;
	localparam int EDPC_ERR_MET_BIT = 9;
	localparam int EDPC_DATA_MET_BIT = 8;
	localparam int EDPC_ERR_THR_LSB = 4;
	localparam int EDPC_DATA_THR_LSB = 0;

	// Interrupt status bits
	localparam int EDPC_IRQ_UP_BIT = 0;
	localparam int EDPC_IRQ_DOWN_BIT = 1;
	localparam int EDPC_IRQ_DATA_BIT = 2;
	localparam int EDPC_IRQ_ERR_BIT = 3;
	localparam int EDPC_IRQ_W = 4;

	// ********************************
	// Reset values and timing
	// ********************************
	localparam logic [3:0] EDPC_THR_RST = 4'h1;
	localparam logic EDPC_AUTO_RST = 1'b1;
	localparam logic [2:0] EDPC_BURST_LEN = 3'h4;
	localparam longint EDPC_CLK_HZ = 50000000;
	localparam longint EDPC_QUIET_MS = 2000;
	localparam longint EDPC_QUIET_CYC = EDPC_QUIET_MS * (EDPC_CLK_HZ / 1000);
	localparam int EDPC_SEQ_CYC = 16;

	typedef struct packed {
		logic allow;
		logic auto_up;
		logic auto_dn;
		logic burst_off;
		logic [3:0] err_thr;
		logic [3:0] data_thr;
	} edpc_cfg_t;

	typedef enum logic [1:0] {
		EDPC_DOWN = 2'b00,
		EDPC_GO_UP = 2'b01,
		EDPC_UP = 2'b10,
		EDPC_GO_DOWN = 2'b11
	} edpc_state_t;

endpackage

// >>> sim/edpc_top_tb.sv
// Self-checking bench for the energy detect power control block.
// Assumes the package is compiled first; bench drives every port itself.
`timescale 1ns/10ps
module edpc_top_tb;
	localparam int QCYC = 200;
	localparam int SCYC = 16;
	logic hclk, hresetn, strap_allow, hsel, hwrite, hready;
	logic energy_present, data_event, error_event, rd_dp;
	logic [31:0] haddr, hwdata, hrdata, rnd, base;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] et;
	logic hreadyout, hresp, rx_power_on, detect_pulse, irq;
	int fails, total_checks, pulses, p0;
	logic [31:0] exp_q[$];

	assign hready = hreadyout;

	edpc_top #(.QUIET_CYC(QCYC), .SEQ_CYC(SCYC)) dut_u (.hclk(hclk), .hresetn(hresetn),
		.strap_allow(strap_allow), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .energy_present(energy_present),
		.data_event(data_event), .error_event(error_event), .rx_power_on(rx_power_on),
		.detect_pulse(detect_pulse), .irq(irq));

	// ********************************
	// Helpers
	// ********************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction

	task automatic check_word(input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	task automatic check_bit(input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	task print_verdict;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Single word transfer; holds each phase until hready is seen high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		rd_dp <= !w;
		do @(posedge hclk); while (hready !== 1'b1);
		rd_dp <= 1'b0;
		check_bit(1'b0, hresp);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h00000000);
	endtask

	task automatic ev(input int n, input logic err);
		for (int i = 0; i < n; i++) begin
			@(posedge hclk);
			data_event <= !err;
			error_event <= err;
			@(posedge hclk);
			data_event <= 1'b0;
			error_event <= 1'b0;
			rnd = xs(rnd);
			repeat (rnd[1:0]) @(posedge hclk);
		end
	endtask

	// Bounded wait; the caller compares the level afterwards
	task automatic wait_pwr(input logic v);
		int k;
		k = 0;
		while (rx_power_on !== v && k < 200) begin
			@(posedge hclk);
			k++;
		end
		@(negedge hclk);
	endtask

	// ********************************
	// Clock, monitors, watchdog
	// ********************************
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		if (rd_dp === 1'b1 && hready === 1'b1)
			check_word(exp_q.pop_front(), hrdata);
		if (detect_pulse === 1'b1)
			pulses++;
	end

	initial begin
		repeat (20000) @(posedge hclk);
		fails++;
		print_verdict;
	end

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		{hresetn, hsel, hwrite, data_event, error_event, rd_dp} = 6'h00;
		{strap_allow, energy_present} = 2'b11;
		{haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'h2};
		{fails, total_checks, pulses} = {32'h0, 32'h0, 32'h0};
		rnd = 32'h1F19;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		rd(edpc_pkg::EDPC_CTRL_OFS, 32'h0000E011);
		rd(edpc_pkg::EDPC_IRQ_MASK_OFS, 32'h00000000);
		rnd = xs(rnd);
		bus(1'b1, 8'h0C, rnd);
		rd(8'h0C, 32'h00000000);
		bus(1'b1, edpc_pkg::EDPC_IRQ_MASK_OFS, 32'h0000000F);
		rnd = xs(rnd);
		et = {2'b00, rnd[1:0]} + 4'h1;
		base = 32'h0000E003 | {24'h000000, et, 4'h0};
		bus(1'b1, edpc_pkg::EDPC_CTRL_OFS, base); // no crossover control to turn off here
		// Quiet span must forget the first two events
		ev(2, 1'b0);
		repeat (QCYC + 50) @(posedge hclk);
		ev(1, 1'b0);
		// One error short of the threshold leaves both flags clear
		ev(et - 1, 1'b1);
		rd(edpc_pkg::EDPC_CTRL_OFS, base);
		ev(1, 1'b1);
		repeat (30) @(posedge hclk);
		check_bit(1'b0, rx_power_on);
		p0 = pulses;
		ev(2, 1'b0);
		wait_pwr(1'b1);
		check_bit(1'b1, rx_power_on);
		check_word(32'h4, pulses - p0);
		rd(edpc_pkg::EDPC_CTRL_OFS, base | 32'h00000700);
		rd(edpc_pkg::EDPC_CTRL_OFS, base | 32'h00000400);
		check_bit(1'b1, irq);
		rd(edpc_pkg::EDPC_IRQ_STAT_OFS, 32'h0000000D);
		bus(1'b1, edpc_pkg::EDPC_IRQ_STAT_OFS, 32'h0000000F);
		@(negedge hclk);
		check_bit(1'b0, irq);
		bus(1'b1, edpc_pkg::EDPC_IRQ_MASK_OFS, 32'h00000002);
		energy_present <= 1'b0;
		wait_pwr(1'b0);
		check_bit(1'b0, rx_power_on);
		check_bit(1'b1, irq);
		rd(edpc_pkg::EDPC_IRQ_STAT_OFS, 32'h00000002);
		bus(1'b1, edpc_pkg::EDPC_IRQ_STAT_OFS, 32'h00000002);
		// Manual toggle up with a single pulse, then back down
		energy_present <= 1'b1;
		p0 = pulses;
		bus(1'b1, edpc_pkg::EDPC_CTRL_OFS, base | 32'h00001800);
		wait_pwr(1'b1);
		check_bit(1'b1, rx_power_on);
		check_word(32'h1, pulses - p0);
		rd(edpc_pkg::EDPC_CTRL_OFS, base | 32'h00000C00);
		bus(1'b1, edpc_pkg::EDPC_CTRL_OFS, base | 32'h00001000);
		wait_pwr(1'b0);
		check_bit(1'b0, rx_power_on);
		// Disabled: events are not counted and nothing powers up
		bus(1'b1, edpc_pkg::EDPC_CTRL_OFS, 32'h00006001);
		ev(2, 1'b0);
		repeat (40) @(posedge hclk);
		check_bit(1'b0, rx_power_on);
		rd(edpc_pkg::EDPC_CTRL_OFS, 32'h00006001);
		// Mid-run reset with the strap low: enable comes back clear
		strap_allow <= 1'b0;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		check_bit(1'b0, irq);
		check_bit(1'b0, rx_power_on);
		rd(edpc_pkg::EDPC_CTRL_OFS, 32'h00006011);
		repeat (3) @(posedge hclk);
		print_verdict;
	end
endmodule // edpc_top_tb
